// >>> inc/mem_power_pkg.sv
// constants and types shared by both ends of the memory bus
package mem_power_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // timing, in printed units, and derived cycle counts
    // ------------------------------------------------------------
    localparam int INITIAL_ACCESS_TIME_NS = 40;
    localparam int STOP_MARGIN_NS = 30;
    // least time: rounds up
    localparam int STOP_CYCLES = ((INITIAL_ACCESS_TIME_NS + STOP_MARGIN_NS)
        * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWERDOWN_ENTRY_DELAY_US = 10;
    localparam int ENTRY_CYCLES = (POWERDOWN_ENTRY_DELAY_US * 1000000
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWERDOWN_EXIT_SELECT_PULSE_NS = 200;
    localparam int EXIT_PULSE_CYCLES = (POWERDOWN_EXIT_SELECT_PULSE_NS
        * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // longest time: rounds down
    localparam int POWERDOWN_WAKE_TIME_US = 150;
    localparam int WAKE_CYCLES = POWERDOWN_WAKE_TIME_US * 1000000
        / CLK_PERIOD_PS;
    localparam int POWER_UP_SETTLE_TIME_US = 150;
    localparam int SETTLE_CYCLES = POWER_UP_SETTLE_TIME_US * 1000000
        / CLK_PERIOD_PS;
    localparam int MAX_SELECT_LOW_TIME_US = 4;
    localparam int MAX_LOW_CYCLES = MAX_SELECT_LOW_TIME_US * 1000000
        / CLK_PERIOD_PS;
    localparam int HW_RESET_PULSE_CYCLES = 4;
    localparam int BEAT_CYCLES = 2;
    localparam int GUARD_CYCLES = 4;

    // ------------------------------------------------------------
    // command byte and configuration register zero
    // ------------------------------------------------------------
    localparam int CMD_READ_BIT = 7;
    localparam int CMD_REG_BIT = 6;
    localparam logic [7:0] CFG_ZERO_ADDR = 8'h00;
    localparam logic [15:0] CFG_ZERO_DEFAULT = 16'h8000;
    localparam int PWR_DOWN_BIT = 15;

    typedef enum logic [2:0] {
        CMD_READ = 3'b000,
        CMD_WRITE = 3'b001,
        CMD_CFG_READ = 3'b010,
        CMD_CFG_WRITE = 3'b011,
        CMD_WAKE = 3'b100,
        CMD_HW_RESET = 3'b101
    } host_cmd_type;

endpackage

// >>> inc/memory_bus_if.sv
// memory bus between host controller and memory device
`timescale 1ns/1ps
interface memory_bus_if;
    logic sel_n;
    logic bus_ck;
    logic hw_reset_n;
    logic [7:0] host_dq;
    logic host_dq_oe;
    logic [7:0] dev_dq;
    logic dev_dq_oe;
    logic [7:0] dq;

    // resolved data bus level
    assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 8'h00);

    modport host(
        output sel_n,
        output bus_ck,
        output hw_reset_n,
        output host_dq,
        output host_dq_oe,
        input dq
    );
    modport device(
        input sel_n,
        input bus_ck,
        input hw_reset_n,
        input dq,
        output dev_dq,
        output dev_dq_oe
    );
endinterface

// >>> logic/mem_device_end.sv
// memory device end: standby, clock stop and deep power down
//
// Contract
// - select high: standby, only select and reset watched
// - idle clock in data phase: enter clock stop
// - clock stop during read: keep driving read data
// - clock toggles again: resume paused transfer
// - host ends transfer before max select-low time
// - config zero bit 15 cleared: deep power down
// - after entry write: refresh halts, low power
// - array contents invalid once power down entered
// - select low-high wakes; transaction is dummy
// - host holds wake select low 200 ns
// - power-on or hardware reset also wakes
// - in power down only select, reset watched
// - wake or hw reset: standby within 150 us
// - power-on exit needs power-up settle time
// - any exit restores power-on state and defaults
// - stacked-die variant has no deep power down
`timescale 1ns/1ps
module mem_device_end
    import mem_power_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter bit STACKED_DIE = 1'b0,
    parameter int WAKE_CYC = WAKE_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES
)(
    input wire logic sys_clk,
    input wire logic reset,
    memory_bus_if.device bus,
    output logic standby_r,
    output logic clock_stop_r,
    output logic deep_power_down_r,
    output logic refresh_on_r,
    output logic array_valid_r,
    output logic [15:0] config_r
);

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);

    typedef enum logic [3:0] {
        SETTLE = 4'b0000,
        STANDBY = 4'b0001,
        CMD0 = 4'b0010,
        CMD1 = 4'b0011,
        DATA = 4'b0100,
        CLK_STOP = 4'b0101,
        PD_ENTER = 4'b0110,
        POWER_DOWN = 4'b0111,
        WAKE = 4'b1000,
        HW_RESET = 4'b1001
    } dev_state_type;

    dev_state_type state_r;
    logic [CNT_W-1:0] cnt_r;
    logic ck_prev_r;
    logic sel_prev_r;
    logic rd_r;
    logic reg_r;
    logic half_r;
    logic [AW-1:0] addr_r;
    logic [7:0] stage_r;
    logic [15:0] cfg_r;
    logic [7:0] dq_out_r;
    logic dq_oe_r;
    logic [7:0] mem [DEPTH];

    logic beat;
    logic sel_rise;
    logic xfer;
    logic pd_go;
    logic cfg_hit;

    assign beat = bus.bus_ck != ck_prev_r;
    assign sel_rise = bus.sel_n & ~sel_prev_r;
    assign xfer = beat & ~bus.sel_n
        & (state_r == DATA || state_r == CLK_STOP);
    assign pd_go = ~cfg_r[PWR_DOWN_BIT] & ~STACKED_DIE;
    assign cfg_hit = addr_r == AW'(CFG_ZERO_ADDR);

    assign bus.dev_dq = dq_out_r;
    assign bus.dev_dq_oe = dq_oe_r;

    // ------------------------------------------------------------
    // edge history of select and bus clock
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ck_prev_r <= 1'b0;
            sel_prev_r <= 1'b1;
        end else begin
            ck_prev_r <= bus.bus_ck;
            sel_prev_r <= bus.sel_n;
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= SETTLE;
            cnt_r <= '0;
        end else if (!bus.hw_reset_n) begin
            state_r <= HW_RESET;
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            unique case (state_r)
                SETTLE: begin
                    if (cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
                        state_r <= STANDBY;
                    end
                end
                STANDBY: begin
                    // clock and data are not looked at here
                    if (!bus.sel_n) begin
                        state_r <= CMD0;
                    end
                end
                CMD0, CMD1: begin
                    if (bus.sel_n) begin
                        state_r <= STANDBY;
                    end else if (beat) begin
                        state_r <= state_r == CMD0 ? CMD1 : DATA;
                        cnt_r <= '0;
                    end
                end
                DATA: begin
                    if (bus.sel_n) begin
                        state_r <= pd_go ? PD_ENTER : STANDBY;
                        cnt_r <= '0;
                    end else if (beat) begin
                        cnt_r <= '0;
                    end else if (cnt_r == CNT_W'(STOP_CYCLES - 1)) begin
                        state_r <= CLK_STOP;
                    end
                end
                CLK_STOP: begin
                    if (bus.sel_n) begin
                        state_r <= pd_go ? PD_ENTER : STANDBY;
                        cnt_r <= '0;
                    end else if (beat) begin
                        state_r <= DATA;
                        cnt_r <= '0;
                    end
                end
                PD_ENTER: begin
                    if (sel_rise) begin
                        state_r <= WAKE;
                        cnt_r <= '0;
                    end else if (cnt_r == CNT_W'(ENTRY_CYCLES - 1)) begin
                        state_r <= POWER_DOWN;
                    end
                end
                POWER_DOWN: begin
                    // only a select rise or reset gets out of here
                    if (sel_rise) begin
                        state_r <= WAKE;
                        cnt_r <= '0;
                    end
                end
                WAKE: begin
                    if (cnt_r == CNT_W'(WAKE_CYC - 1)) begin
                        state_r <= STANDBY;
                    end
                end
                HW_RESET: begin
                    state_r <= WAKE;
                    cnt_r <= '0;
                end
                default: begin
                    state_r <= SETTLE;
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // command capture and address tracking
    // ------------------------------------------------------------
    // a dummy wake transaction never reaches CMD0, so it does nothing
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_r <= 1'b0;
            reg_r <= 1'b0;
            half_r <= 1'b0;
            addr_r <= '0;
            stage_r <= 8'h00;
        end else if (state_r == CMD0 && beat && !bus.sel_n) begin
            rd_r <= bus.dq[CMD_READ_BIT];
            reg_r <= bus.dq[CMD_REG_BIT];
        end else if (state_r == CMD1 && beat && !bus.sel_n) begin
            addr_r <= bus.dq[AW-1:0];
            half_r <= 1'b0;
        end else if (xfer) begin
            if (reg_r) begin
                half_r <= ~half_r;
                if (!half_r) begin
                    stage_r <= bus.dq;
                end
            end else begin
                addr_r <= addr_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration register zero
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg_r <= CFG_ZERO_DEFAULT;
        end else if (state_r == HW_RESET || state_r == WAKE) begin
            cfg_r <= CFG_ZERO_DEFAULT;
        end else if (xfer && !rd_r && reg_r && half_r && cfg_hit) begin
            cfg_r <= {stage_r, bus.dq};
        end
    end

    // ------------------------------------------------------------
    // memory array
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (xfer && !rd_r && !reg_r) begin
            mem[addr_r] <= bus.dq;
        end
    end

    // without refresh the array rots, so only a new write revalidates
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            array_valid_r <= 1'b0;
        end else if (state_r == PD_ENTER) begin
            array_valid_r <= 1'b0;
        end else if (xfer && !rd_r && !reg_r) begin
            array_valid_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read data drive
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dq_out_r <= 8'h00;
            dq_oe_r <= 1'b0;
        end else if (bus.sel_n
                || (state_r != DATA && state_r != CLK_STOP)) begin
            dq_oe_r <= 1'b0;
        end else if (xfer && rd_r) begin
            dq_oe_r <= 1'b1;
            if (reg_r) begin
                dq_out_r <= half_r ? cfg_r[7:0] : cfg_r[15:8];
            end else begin
                dq_out_r <= mem[addr_r];
            end
        end else if (xfer) begin
            dq_oe_r <= 1'b0;
        end
        // otherwise data and enable hold, also through clock stop
    end

    // ------------------------------------------------------------
    // status outputs, one cycle behind the state
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            standby_r <= 1'b0;
            clock_stop_r <= 1'b0;
            deep_power_down_r <= 1'b0;
            refresh_on_r <= 1'b1;
            config_r <= CFG_ZERO_DEFAULT;
        end else begin
            standby_r <= state_r == STANDBY;
            clock_stop_r <= state_r == CLK_STOP;
            deep_power_down_r <= state_r == POWER_DOWN;
            refresh_on_r <= state_r != PD_ENTER
                && state_r != POWER_DOWN;
            config_r <= cfg_r;
        end
    end

endmodule

// >>> logic/mem_host_end.sv
// host controller end: transfers, clock pause and power-down wake
`timescale 1ns/1ps
module mem_host_end
    import mem_power_pkg::*;
#(
    parameter int WAKE_CYC = WAKE_CYCLES,
    parameter int SETTLE_CYC = SETTLE_CYCLES
)(
    input wire logic sys_clk,
    input wire logic reset,
    memory_bus_if.host bus,
    input wire logic cmd_valid,
    input wire host_cmd_type cmd_code,
    input wire logic [7:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    input wire logic pause,
    output logic cmd_ready_r,
    output logic rsp_valid_r,
    output logic [7:0] rsp_data_r,
    output logic timeout_r,
    output logic power_down_entered_r,
    output logic contents_lost_r,
    output logic reconfig_needed_r
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        H_SETTLE = 4'b0000,
        H_IDLE = 4'b0001,
        H_CA0 = 4'b0010,
        H_CA1 = 4'b0011,
        H_BEAT = 4'b0100,
        H_END = 4'b0101,
        H_RD_WAIT = 4'b0110,
        H_WAKE_LOW = 4'b0111,
        H_RST_LOW = 4'b1000,
        H_WAIT = 4'b1001
    } host_state_type;

    host_state_type state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] low_r;
    logic [3:0] ph_r;
    logic sel_n_r;
    logic ck_r;
    logic rst_n_r;
    logic [7:0] dq_r;
    logic oe_r;
    host_cmd_type code_r;
    logic [7:0] addr_r;
    logic [15:0] data_r;
    logic beat_r;
    logic tick;
    logic is_rd;
    logic is_reg;
    logic in_xfer;

    assign tick = ph_r == 4'(BEAT_CYCLES - 1);
    assign is_rd = code_r == CMD_READ || code_r == CMD_CFG_READ;
    assign is_reg = code_r == CMD_CFG_READ || code_r == CMD_CFG_WRITE;
    assign in_xfer = state_r inside {H_CA0, H_CA1, H_BEAT, H_END, H_RD_WAIT};

    assign bus.sel_n = sel_n_r;
    assign bus.bus_ck = ck_r;
    assign bus.hw_reset_n = rst_n_r;
    assign bus.host_dq = dq_r;
    assign bus.host_dq_oe = oe_r;

    // ------------------------------------------------------------
    // beat pacing: one clock edge every BEAT_CYCLES
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ph_r <= 4'h0;
        end else begin
            ph_r <= tick ? 4'h0 : ph_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // transfer state machine and bus drive
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= H_SETTLE;
            cnt_r <= '0;
            low_r <= '0;
            sel_n_r <= 1'b1;
            ck_r <= 1'b0;
            rst_n_r <= 1'b1;
            dq_r <= 8'h00;
            oe_r <= 1'b0;
            cmd_ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
            timeout_r <= 1'b0;
            code_r <= CMD_READ;
            addr_r <= 8'h00;
            data_r <= 16'h0000;
            beat_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            low_r <= sel_n_r ? '0 : low_r + 1'b1;
            rsp_valid_r <= 1'b0;
            timeout_r <= 1'b0;
            if (in_xfer && low_r == CNT_W'(MAX_LOW_CYCLES - 1)) begin
                // a pause may not stretch select past the limit
                sel_n_r <= 1'b1;
                oe_r <= 1'b0;
                timeout_r <= 1'b1;
                cmd_ready_r <= 1'b1;
                state_r <= H_IDLE;
            end else begin
                unique case (state_r)
                    H_SETTLE: begin
                        if (cnt_r
                                == CNT_W'(SETTLE_CYC + GUARD_CYCLES - 1)) begin
                            cmd_ready_r <= 1'b1;
                            state_r <= H_IDLE;
                        end
                    end
                    H_IDLE: begin
                        if (cmd_valid && cmd_ready_r) begin
                            cmd_ready_r <= 1'b0;
                            code_r <= cmd_code;
                            addr_r <= cmd_addr;
                            data_r <= cmd_data;
                            beat_r <= 1'b0;
                            cnt_r <= '0;
                            if (cmd_code == CMD_HW_RESET) begin
                                rst_n_r <= 1'b0;
                                state_r <= H_RST_LOW;
                            end else if (cmd_code == CMD_WAKE
                                    || power_down_entered_r) begin
                                sel_n_r <= 1'b0;
                                state_r <= H_WAKE_LOW;
                            end else begin
                                sel_n_r <= 1'b0;
                                state_r <= H_CA0;
                            end
                        end
                    end
                    H_CA0: begin
                        if (tick) begin
                            dq_r <= {is_rd, is_reg, 6'h00};
                            oe_r <= 1'b1;
                            ck_r <= ~ck_r;
                            state_r <= H_CA1;
                        end
                    end
                    H_CA1: begin
                        if (tick) begin
                            dq_r <= addr_r;
                            ck_r <= ~ck_r;
                            state_r <= H_BEAT;
                        end
                    end
                    H_BEAT: begin
                        if (!pause && tick) begin
                            ck_r <= ~ck_r;
                            if (is_rd) begin
                                oe_r <= 1'b0;
                                state_r <= H_RD_WAIT;
                            end else begin
                                dq_r <= (is_reg && !beat_r) ?
                                    data_r[15:8] : data_r[7:0];
                                beat_r <= 1'b1;
                                if (!is_reg || beat_r) begin
                                    state_r <= H_END;
                                end
                            end
                        end
                    end
                    H_END, H_RD_WAIT: begin
                        if (!pause && tick) begin
                            if (state_r == H_RD_WAIT) begin
                                rsp_data_r <= bus.dq;
                                rsp_valid_r <= 1'b1;
                            end
                            sel_n_r <= 1'b1;
                            oe_r <= 1'b0;
                            cmd_ready_r <= 1'b1;
                            state_r <= H_IDLE;
                        end
                    end
                    H_WAKE_LOW: begin
                        if (cnt_r == CNT_W'(EXIT_PULSE_CYCLES - 1)) begin
                            sel_n_r <= 1'b1;
                            cnt_r <= '0;
                            state_r <= H_WAIT;
                        end
                    end
                    H_RST_LOW: begin
                        if (cnt_r == CNT_W'(HW_RESET_PULSE_CYCLES - 1)) begin
                            rst_n_r <= 1'b1;
                            cnt_r <= '0;
                            state_r <= H_WAIT;
                        end
                    end
                    H_WAIT: begin
                        if (cnt_r == CNT_W'(WAKE_CYC + GUARD_CYCLES - 1)) begin
                            cmd_ready_r <= 1'b1;
                            state_r <= H_IDLE;
                        end
                    end
                    default: begin
                        state_r <= H_IDLE;
                        cmd_ready_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // power-down bookkeeping for the user
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            power_down_entered_r <= 1'b0;
            contents_lost_r <= 1'b0;
            reconfig_needed_r <= 1'b0;
        end else if (state_r == H_WAIT) begin
            contents_lost_r <= contents_lost_r | power_down_entered_r;
            power_down_entered_r <= 1'b0;
            reconfig_needed_r <= 1'b1;
        end else if (state_r == H_END && !pause && tick) begin
            if (code_r == CMD_CFG_WRITE && addr_r == CFG_ZERO_ADDR) begin
                power_down_entered_r <= ~data_r[PWR_DOWN_BIT];
                reconfig_needed_r <= 1'b0;
            end else if (code_r == CMD_WRITE) begin
                contents_lost_r <= 1'b0;
            end
        end
    end

endmodule

// >>> verif/mem_bus_props.sv
// assertions on the memory bus between host and device ends
`timescale 1ns/1ps
module mem_bus_props
    import mem_power_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sel_n,
    input wire logic bus_ck,
    input wire logic hw_reset_n,
    input wire logic host_dq_oe,
    input wire logic [7:0] dev_dq,
    input wire logic dev_dq_oe
);
    // ----
    // select-low span, saturates so it never wraps
    // ----
    logic [7:0] low_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (reset || sel_n) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'hFF) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_SEL_HIGH_RELEASE: assert property (sel_n [*2] |-> !dev_dq_oe)
        else $error("device drives data while deselected");
    AST_DRIVE_NEEDS_SEL: assert property ($rose(dev_dq_oe) |->
        !sel_n && !$past(sel_n)) else $error("drive without select");
    AST_NO_CONTENTION: assert property (!(host_dq_oe && dev_dq_oe))
        else $error("both ends drive data");
    AST_CLK_STOP_HOLD: assert property (($stable(bus_ck) && dev_dq_oe
        && !sel_n) [*3] |-> $stable(dev_dq)) else $error("read data moved");
    AST_MAX_SELECT_LOW: assert property (!sel_n |->
        low_cnt_r < MAX_LOW_CYCLES) else $error("select low too long");
    AST_HW_RESET_PULSE: assert property ($fell(hw_reset_n) |->
        !hw_reset_n [*4]) else $error("hardware reset pulse short");
    AST_RESET_IDLE: assert property ($fell(reset) |-> sel_n &&
        !bus_ck && hw_reset_n && !dev_dq_oe && !host_dq_oe)
        else $error("bus not idle after reset");
    AST_CK_QUIET: assert property (sel_n [*3] |-> $stable(bus_ck))
        else $error("bus clock moves while deselected");
endmodule

// >>> verif/memory_interface_power_modes_tb_top.sv
// self-checking bench for both ends of the memory bus
`timescale 1ns/1ps
module memory_interface_power_modes_tb_top;
    import mem_power_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    host_cmd_type cmd_code = CMD_READ;
    logic [7:0] cmd_addr = 8'h00;
    logic [15:0] cmd_data = 16'h0000;
    logic pause = 1'b0;
    logic cmd_ready_r, rsp_valid_r, pd_r, lost_r, recfg_r, tmo;
    logic stby, cstop, pdown, refr, avalid;
    logic [7:0] rsp_data_r;
    logic [7:0] rnd;
    logic [15:0] cfg;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int checks_done = 0;
    memory_bus_if memory_bus_if_i ();
    always #12.5 sys_clk = ~sys_clk;
    mem_host_end #(.WAKE_CYC(20), .SETTLE_CYC(20)) mem_host_end_i (
        .sys_clk(sys_clk), .reset(reset), .bus(memory_bus_if_i.host),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .pause(pause), .cmd_ready_r(cmd_ready_r),
        .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .timeout_r(tmo),
        .power_down_entered_r(pd_r), .contents_lost_r(lost_r),
        .reconfig_needed_r(recfg_r));
    mem_device_end #(.WAKE_CYC(20), .SETTLE_CYC(20)) mem_device_end_i (
        .sys_clk(sys_clk), .reset(reset), .bus(memory_bus_if_i.device),
        .standby_r(stby), .clock_stop_r(cstop), .deep_power_down_r(pdown),
        .refresh_on_r(refr), .array_valid_r(avalid), .config_r(cfg));
    mem_bus_props mem_bus_props_i (.sys_clk(sys_clk), .reset(reset),
        .sel_n(memory_bus_if_i.sel_n), .bus_ck(memory_bus_if_i.bus_ck),
        .hw_reset_n(memory_bus_if_i.hw_reset_n),
        .host_dq_oe(memory_bus_if_i.host_dq_oe),
        .dev_dq(memory_bus_if_i.dev_dq),
        .dev_dq_oe(memory_bus_if_i.dev_dq_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_rdy();
        for (int n = 0; n < 400 && cmd_ready_r !== 1'b1; n++) cyc(1);
    endtask
    task automatic send(host_cmd_type c, logic [7:0] a, logic [15:0] d);
        wait_rdy();
        cmd_code = c;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        cyc(1);
        cmd_valid = 1'b0;
        wait_rdy();
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // results are compared in arrival order
    always @(posedge sys_clk) begin
        if (rsp_valid_r === 1'b1) check(rsp_data_r, exp_q.pop_front());
    end
    initial begin
        cyc(5000);
        mismatches++;
        end_of_test();
    end
    initial begin
        rnd = 8'($urandom(41));
        cyc(10);
        reset = 1'b0;
        wait_rdy();
        check({stby, refr, cfg}, {2'b11, CFG_ZERO_DEFAULT});
        rnd = 8'($urandom);
        send(CMD_WRITE, 8'h5A, {8'h00, rnd});
        exp_q.push_back(rnd);
        pause = 1'b1;
        fork
            send(CMD_READ, 8'h5A, 16'h0000);
            begin
                cyc(20);
                check(cstop, 1'b1);
                pause = 1'b0;
                cyc(2);
                pause = 1'b1;
                cyc(8);
                check({cstop, memory_bus_if_i.dq}, {1'b1, rnd});
                pause = 1'b0;
            end
        join
        cyc(1);
        check(exp_q.size(), 16'h0000);
        pause = 1'b1;
        send(CMD_READ, 8'h5A, 16'h0000);
        check(tmo, 1'b1);
        pause = 1'b0;
        $display("test clock stop done");
        send(CMD_CFG_WRITE, CFG_ZERO_ADDR, 16'h0000);
        cyc(ENTRY_CYCLES + 4);
        check({pdown, refr, avalid, pd_r}, 4'b1001);
        send(CMD_WRITE, 8'h5A, 16'h00FF);
        check({pdown, avalid, lost_r, recfg_r, stby}, 5'b00111);
        check(cfg, CFG_ZERO_DEFAULT);
        $display("test select wake done");
        send(CMD_CFG_WRITE, CFG_ZERO_ADDR, 16'h0000);
        cyc(ENTRY_CYCLES + 4);
        check(pdown, 1'b1);
        send(CMD_HW_RESET, 8'h00, 16'h0000);
        check({pdown, refr, stby, cfg}, {3'b011, CFG_ZERO_DEFAULT});
        $display("test hardware reset wake done");
        send(CMD_CFG_WRITE, CFG_ZERO_ADDR, 16'h0000);
        cyc(ENTRY_CYCLES + 4);
        reset = 1'b1;
        cyc(3);
        reset = 1'b0;
        cyc(1);
        check({pdown, stby}, 2'b00);
        cyc(24);
        check({pdown, stby, cfg}, {2'b01, CFG_ZERO_DEFAULT});
        $display("test power-on wake done");
        end_of_test();
    end
endmodule
